// ===== rtl/etmap_consts.svh
`ifndef ETMAP_CONSTS_SVH
`define ETMAP_CONSTS_SVH
`define ETMAP_NUM_PRESETS 2
`define ETMAP_NUM_POINTS 12
`define ETMAP_COARSE_POINTS 8
`define ETMAP_COARSE_STEP 8
`define ETMAP_GAIN_POINTS 6
`define ETMAP_TIME_W 16
`define ETMAP_LEVEL_W 8
`define ETMAP_OFFSET_W 4
`define ETMAP_GAIN_W 6
`define ETMAP_CRC_W 8
`define ETMAP_CRC_POLY 8'h07
`define ETMAP_CRC_INIT 8'hFF
`endif

// ===== rtl/etmap_core.sv
`timescale 1ns/1ps
`include "etmap_consts.svh"
module etmap_core
   import etmap_pkg::*;
#(
   parameter int NPT = `ETMAP_NUM_POINTS,
   parameter int TW = `ETMAP_TIME_W
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic wake_i,
   input wire logic thr_wr_i,
   input wire logic thr_preset_i,
   input wire logic [3:0] thr_idx_i,
   input wire logic [TW-1:0] thr_time_i,
   input wire logic [7:0] thr_level_i,
   input wire logic [7:0] thr_crc_i,
   input wire logic thr_commit_i,
   input wire logic [3:0] thr_offset_i,
   input wire logic gain_wr_i,
   input wire logic [2:0] gain_idx_i,
   input wire logic [TW-1:0] gain_time_i,
   input wire logic [5:0] gain_level_i,
   input wire logic [5:0] gain_init_i,
   input wire logic meas_req_i,
   input wire logic meas_preset_i,
   input wire logic [TW-1:0] record_len_i,
   output logic crc_err_o,
   output logic meas_busy_o,
   output logic meas_rejected_o,
   output logic [5:0] gain_o,
   output logic [7:0] threshold_o
);
   localparam int LW = `ETMAP_LEVEL_W;
   localparam int GP = `ETMAP_GAIN_POINTS;

   typedef struct packed {
      logic [1:0][NPT-1:0][TW-1:0] seg_time;
      logic [1:0][NPT-1:0][LW-1:0] seg_level;
      logic [1:0] crc_bad;
      logic [GP-1:0][TW-1:0] g_time;
      logic [GP-1:0][5:0] g_level;
      logic [5:0] g_init;
      logic [3:0] offset;
      etmap_phase_t phase;
      logic preset;
      logic [TW-1:0] tick;
      logic [TW-1:0] rec_len;
      logic rejected;
      logic [5:0] gain;
      logic [7:0] thr;
      logic err;
      logic busy;
   } etmap_state_t;

   etmap_state_t s_reg;
   etmap_state_t s_next;

   // CRC-8 over one preset's stored points, time then level
   function automatic logic [7:0] etmap_crc(
      input logic [NPT-1:0][TW-1:0] t,
      input logic [NPT-1:0][LW-1:0] l
   );
      logic [7:0] c;
      logic [TW+LW-1:0] w;
      c = `ETMAP_CRC_INIT;
      for (int p = 0; p < NPT; p++) begin
         w = {t[p], l[p]};
         for (int b = TW + LW - 1; b >= 0; b--) begin
            if (c[7] ^ w[b]) begin
               c = {c[6:0], 1'b0} ^ `ETMAP_CRC_POLY;
            end else begin
               c = {c[6:0], 1'b0};
            end
         end
      end
      return c;
   endfunction : etmap_crc

   // Effective 8-bit level of a point: coarse scaling and offset for the first 8 points, raw level for the rest
   function automatic logic [7:0] etmap_level(
      input int p,
      input logic [LW-1:0] raw,
      input logic [3:0] off
   );
      logic [8:0] v;
      if (p < `ETMAP_COARSE_POINTS) begin
         v = {1'b0, raw[4:0], 3'b000} + {5'h00, off};
         etmap_level = v[8] ? 8'hFF : v[7:0];
      end else begin
         etmap_level = raw;
      end
   endfunction : etmap_level

   logic [TW-1:0] abs_t;
   logic [7:0] thr_sel;
   logic [5:0] gain_sel;
   logic [7:0] crc_calc;
   logic bad_p;
   logic [TW-1:0] g_end;

   always_comb begin
      s_next = s_reg;
      s_next.rejected = 1'b0;
      bad_p = thr_preset_i;
      // Threshold write touches only the addressed preset
      if (thr_wr_i && thr_idx_i < 4'(NPT)) begin
         s_next.seg_time[bad_p][thr_idx_i] = thr_time_i;
         s_next.seg_level[bad_p][thr_idx_i] = thr_level_i;
      end
      crc_calc = etmap_crc(s_reg.seg_time[bad_p], s_reg.seg_level[bad_p]);
      if (thr_commit_i) begin
         s_next.crc_bad[bad_p] = (crc_calc != thr_crc_i);
      end
      s_next.offset = thr_offset_i;
      if (gain_wr_i && gain_idx_i < 3'(GP)) begin
         s_next.g_time[gain_idx_i] = gain_time_i;
         s_next.g_level[gain_idx_i] = gain_level_i;
      end
      s_next.g_init = gain_init_i;

      // Threshold level at the current record time
      abs_t = '0;
      thr_sel = etmap_level(0, s_reg.seg_level[s_reg.preset][0],
         s_reg.offset);
      for (int p = 0; p < NPT; p++) begin
         abs_t = abs_t + s_reg.seg_time[s_reg.preset][p];
         if (s_reg.tick >= abs_t) begin
            thr_sel = etmap_level(p, s_reg.seg_level[s_reg.preset][p],
               s_reg.offset);
         end
      end
      // Gain steps through the shared schedule, last one held
      abs_t = '0;
      gain_sel = s_reg.g_init;
      for (int g = 0; g < GP; g++) begin
         abs_t = abs_t + s_reg.g_time[g];
         if (s_reg.tick >= abs_t) begin
            gain_sel = s_reg.g_level[g];
         end
      end
      g_end = abs_t;

      unique case (s_reg.phase)
         ETMAP_IDLE: begin
            s_next.tick = '0;
            s_next.gain = s_reg.g_init;
            s_next.thr = 8'h00;
            if (meas_req_i) begin
               if (s_reg.crc_bad != 2'b00) begin
                  s_next.rejected = 1'b1;
               end else begin
                  s_next.phase = ETMAP_RECORD;
                  s_next.preset = meas_preset_i;
                  s_next.rec_len = record_len_i;
               end
            end
         end
         ETMAP_RECORD: begin
            s_next.gain = gain_sel;
            s_next.thr = thr_sel;
            s_next.tick = s_reg.tick + 1'b1;
            if (s_reg.tick >= s_reg.rec_len) begin
               s_next.phase = ETMAP_IDLE;
            end
         end
      endcase

      if (wake_i) begin
         s_next.seg_time = '0;
         s_next.seg_level = '0;
         s_next.crc_bad = 2'b11;
         s_next.phase = ETMAP_IDLE;
      end
      // Output flags registered from the next state, no extra lag
      s_next.err = s_next.crc_bad != 2'b00;
      s_next.busy = s_next.phase == ETMAP_RECORD;
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         s_reg <= '0;
         s_reg.crc_bad <= 2'b11;
         s_reg.err <= 1'b1;
         s_reg.phase <= ETMAP_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign crc_err_o = s_reg.err;
   assign meas_busy_o = s_reg.busy;
   assign meas_rejected_o = s_reg.rejected;
   assign gain_o = s_reg.gain;
   assign threshold_o = s_reg.thr;

   a_reject_on_err: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (meas_req_i && !meas_busy_o && crc_err_o && !wake_i)
      |=> meas_rejected_o && !meas_busy_o)
      else $error("measurement accepted with CRC error");
   a_no_start_err: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $rose(meas_busy_o) |-> !$past(crc_err_o))
      else $error("record began while CRC error set");
   a_wake_sets_err: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      wake_i |=> crc_err_o && !meas_busy_o)
      else $error("wake-up did not raise CRC error");
   a_err_holds: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (crc_err_o && !thr_commit_i) |=> crc_err_o)
      else $error("CRC error cleared without commit");
   a_idle_gain: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      !meas_busy_o ##1 (!meas_busy_o && !$past(rst_i, 2))
      |-> gain_o == $past(gain_init_i, 2))
      else $error("idle gain not initial gain");
   a_idle_thr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !meas_busy_o ##1 !meas_busy_o |-> threshold_o == 8'h00)
      else $error("threshold output active while idle");
   a_reject_req: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      meas_rejected_o |-> $past(meas_req_i) && $past(crc_err_o))
      else $error("rejection without request under error");
   a_start_req: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      $rose(meas_busy_o) |-> $past(meas_req_i) && s_reg.tick == '0)
      else $error("record began without request");
   a_busy_not_rej: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      !(meas_busy_o && meas_rejected_o))
      else $error("busy and rejected together");
   a_reset_err: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      $past(rst_i) |-> crc_err_o && !meas_busy_o && !meas_rejected_o)
      else $error("wrong flags after reset");
   a_tick_step: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (meas_busy_o && $past(meas_busy_o))
      |-> s_reg.tick == $past(s_reg.tick) + 1'b1)
      else $error("record time did not advance");
   a_rec_stable: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (meas_busy_o && $past(meas_busy_o))
      |-> $stable(s_reg.rec_len) && $stable(s_reg.preset))
      else $error("record settings changed in record");
   a_rec_to_idle: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (meas_busy_o && s_reg.tick >= s_reg.rec_len) |=> !meas_busy_o)
      else $error("record overran its length");
   a_commit_only: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (!thr_commit_i && !wake_i) |=> $stable(s_reg.crc_bad))
      else $error("CRC flag changed without commit");
   a_p0_keeps_p1: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (thr_wr_i && !thr_preset_i && !wake_i)
      |=> $stable(s_reg.seg_time[1]) && $stable(s_reg.seg_level[1]))
      else $error("write to first preset touched second");
   a_p1_keeps_p0: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (thr_wr_i && thr_preset_i && !wake_i)
      |=> $stable(s_reg.seg_time[0]) && $stable(s_reg.seg_level[0]))
      else $error("write to second preset touched first");
   a_thr_wr_lands: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (thr_wr_i && thr_idx_i < 4'(NPT) && !wake_i)
      |=> s_reg.seg_level[$past(thr_preset_i)][$past(thr_idx_i)]
         == $past(thr_level_i))
      else $error("threshold point write lost");
   a_thr_idx_out: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (thr_wr_i && thr_idx_i >= 4'(NPT) && !wake_i)
      |=> $stable(s_reg.seg_time) && $stable(s_reg.seg_level))
      else $error("out of range threshold index stored");
   a_gain_wr_lands: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (gain_wr_i && gain_idx_i < 3'(GP))
      |=> s_reg.g_level[$past(gain_idx_i)] == $past(gain_level_i)
         && s_reg.g_time[$past(gain_idx_i)] == $past(gain_time_i))
      else $error("gain point write lost");
   a_gain_idx_out: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (gain_wr_i && gain_idx_i >= 3'(GP))
      |=> $stable(s_reg.g_time) && $stable(s_reg.g_level))
      else $error("out of range gain index stored");
   a_wake_clears: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      wake_i |=> s_reg.seg_time == '0 && s_reg.seg_level == '0)
      else $error("wake-up left threshold map");
   a_first_gain: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (meas_busy_o && $past(meas_busy_o)
         && $past(s_reg.tick) < $past(s_reg.g_time[0]))
      |-> gain_o == $past(s_reg.g_init))
      else $error("gain left initial before first point");
   a_last_gain: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (meas_busy_o && $past(meas_busy_o) && $past(s_reg.tick) >= $past(g_end))
      |-> gain_o == $past(s_reg.g_level[GP-1]))
      else $error("last gain setting not held");
endmodule : etmap_core

// ===== rtl/etmap_pkg.sv
package etmap_pkg;
   typedef enum logic [1:0] {
      ETMAP_IDLE,
      ETMAP_RECORD
   } etmap_phase_t;
endpackage : etmap_pkg

// ===== verif/echo_threshold_tvg_map_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_count++; \
   $display("FAIL %s exp %0h got %0h", n, e, a); end end
module echo_threshold_tvg_map_tb_top;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic wake_i = 1'b0;
   logic thr_wr_i, thr_preset_i, thr_commit_i;
   logic [3:0] thr_idx_i;
   logic [15:0] thr_time_i;
   logic [7:0] thr_level_i, thr_crc_i;
   logic [3:0] thr_offset_i = 4'h3;
   logic gain_wr_i = 1'b0;
   logic [2:0] gain_idx_i = 3'h0;
   logic [15:0] gain_time_i = 16'h0005;
   logic [5:0] gain_level_i = 6'h10;
   logic [5:0] gain_init_i = 6'h08;
   logic meas_req_i = 1'b0;
   logic meas_preset_i = 1'b0;
   logic [15:0] record_len_i = 16'h0014;
   logic crc_err_o, meas_busy_o, meas_rejected_o;
   logic [5:0] gain_o;
   logic [7:0] threshold_o;
   int err_count = 0;
   int checked = 0;
   int n;
   always #2.5 clk_sys_i = ~clk_sys_i;
   etmap_host_model host (.clk_sys_i, .thr_wr_o(thr_wr_i),
      .thr_preset_o(thr_preset_i), .thr_idx_o(thr_idx_i),
      .thr_time_o(thr_time_i), .thr_level_o(thr_level_i),
      .thr_crc_o(thr_crc_i), .thr_commit_o(thr_commit_i));
   etmap_core uut (.clk_sys_i, .rst_i, .wake_i, .thr_wr_i, .thr_preset_i,
      .thr_idx_i, .thr_time_i, .thr_level_i, .thr_crc_i, .thr_commit_i,
      .thr_offset_i, .gain_wr_i, .gain_idx_i, .gain_time_i, .gain_level_i,
      .gain_init_i, .meas_req_i, .meas_preset_i, .record_len_i, .crc_err_o,
      .meas_busy_o, .meas_rejected_o, .gain_o, .threshold_o);
   // Gain expected m cycles into a record: points every 2, then held
   function automatic logic [5:0] exp_gain(input int m);
      int g;
      g = m / 2 - 1;
      if (m < 2) return 6'h08;
      if (g > 5) g = 5;
      return 6'(16 + g);
   endfunction : exp_gain
   // Threshold of the map loaded with seed 20, times 1..12, offset 3
   function automatic logic [7:0] exp_thr(input int m);
      int p;
      p = 0;
      if (m < 0) return 8'h00;
      for (int q = 0; q < 12; q++) begin
         if ((q + 1) * (q + 2) / 2 <= m) p = q;
      end
      return (p < 8) ? 8'(p * 8 + 3) : 8'(32 + p);
   endfunction : exp_thr
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : wrap_up
   task automatic pulse_req(input logic rej);
      @(posedge clk_sys_i);
      meas_req_i <= 1'b1;
      @(posedge clk_sys_i);
      meas_req_i <= 1'b0;
      @(negedge clk_sys_i);
      `CHK("rejected", rej, meas_rejected_o)
      `CHK("busy", !rej, meas_busy_o)
   endtask : pulse_req
   task automatic t_maps();
      `CHK("crc_err init", 1'b1, crc_err_o)
      pulse_req(1'b1);
      host.load(1'b1, 8'h40, 1'b1, 12);
      @(negedge clk_sys_i);
      `CHK("crc_err p1 unwritten", 1'b1, crc_err_o)
      host.load(1'b0, 8'h10, 1'b1, 12);
      @(negedge clk_sys_i);
      `CHK("crc_err both good", 1'b0, crc_err_o)
      host.load(1'b0, 8'h20, 1'b0, 12);
      @(negedge clk_sys_i);
      `CHK("crc_err bad crc", 1'b1, crc_err_o)
      host.load(1'b0, 8'h20, 1'b1, 0);
      host.load(1'b1, 8'h40, 1'b1, 0);
      @(negedge clk_sys_i);
      `CHK("crc_err p2 kept", 1'b0, crc_err_o)
   endtask : t_maps
   task automatic t_meas();
      for (int g = 0; g < 6; g++) begin
         @(posedge clk_sys_i);
         gain_wr_i <= 1'b1;
         gain_idx_i <= 3'(g);
         gain_time_i <= 16'h0002;
         gain_level_i <= 6'(16 + g);
      end
      @(posedge clk_sys_i);
      gain_wr_i <= 1'b0;
      pulse_req(1'b0);
      n = 0;
      for (int k = 0; k < 100 && meas_busy_o === 1'b1; k++) begin
         n++;
         `CHK("gain", exp_gain(n - 2), gain_o)
         `CHK("thr", exp_thr(n - 2), threshold_o)
         @(negedge clk_sys_i);
      end
      `CHK("record cycles", 21, n)
   endtask : t_meas
   task automatic t_wake();
      @(posedge clk_sys_i);
      wake_i <= 1'b1;
      @(posedge clk_sys_i);
      wake_i <= 1'b0;
      @(negedge clk_sys_i);
      `CHK("crc_err wake", 1'b1, crc_err_o)
      pulse_req(1'b1);
   endtask : t_wake
   initial begin
      repeat (12) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(negedge clk_sys_i);
      t_maps();
      t_meas();
      t_wake();
      wrap_up();
   end
endmodule : echo_threshold_tvg_map_tb_top

// ===== verif/etmap_host_model.sv
`timescale 1ns/1ps
module etmap_host_model (
   input wire logic clk_sys_i,
   output logic thr_wr_o,
   output logic thr_preset_o,
   output logic [3:0] thr_idx_o,
   output logic [15:0] thr_time_o,
   output logic [7:0] thr_level_o,
   output logic [7:0] thr_crc_o,
   output logic thr_commit_o
);
   // CRC-8 of the map that load() writes for a given seed
   function automatic logic [7:0] crc_of(input logic [7:0] s);
      logic [7:0] c;
      logic [23:0] w;
      c = 8'hFF;
      for (int i = 0; i < 12; i++) begin
         w = {16'(i + 1), s + 8'(i)};
         for (int b = 23; b >= 0; b--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[b]) ? 8'h07 : 8'h00);
         end
      end
      return c;
   endfunction : crc_of
   initial begin
      thr_wr_o = 1'b0;
      thr_preset_o = 1'b0;
      thr_idx_o = 4'h0;
      thr_time_o = 16'h0000;
      thr_level_o = 8'h00;
      thr_crc_o = 8'h00;
      thr_commit_o = 1'b0;
   end
   // Writes n points, then commits; measurement only after this
   task automatic load(input logic p, input logic [7:0] s, input logic good,
                       input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys_i);
         thr_wr_o <= 1'b1;
         thr_preset_o <= p;
         thr_idx_o <= 4'(i);
         thr_time_o <= 16'(i + 1);
         thr_level_o <= s + 8'(i);
      end
      @(posedge clk_sys_i);
      thr_wr_o <= 1'b0;
      thr_preset_o <= p;
      thr_commit_o <= 1'b1;
      thr_crc_o <= crc_of(s) ^ {7'h00, !good};
      @(posedge clk_sys_i);
      thr_commit_o <= 1'b0;
   endtask : load
endmodule : etmap_host_model
